// ===== verif/test_watchdog_and_reset_flags.sv
`timescale 1ns/10ps
`default_nettype none
module test_watchdog_and_reset_flags;
   // ****************************************
   // Stimulus and observed signals
   // ****************************************
   logic        clk;      // System clock
   logic        rstn;     // Synchronous reset, active low
   logic [7:0]  addr;     // Register address
   logic        io;       // I/O space select
   logic        wr_s;     // Write strobe
   logic        rd_s;     // Read strobe
   logic [7:0]  wdata;    // Write data
   logic [7:0]  rdata;    // Read data
   logic        por;      // Power-on event
   logic        bor;      // Brown-out event
   logic        pin;      // Pin reset event
   logic        fuse_n;   // Always-on fuse
   logic        gie;      // Global interrupt enable
   logic        ack;      // Vector executing
   logic        restart;  // Restart instruction
   logic        tick;     // Oscillator tick, held high = one per cycle
   logic        irq;      // Interrupt request
   logic        rst_p;    // Reset pulse
   logic [15:0] pc;       // Start address
   int          n_fail;   // Mismatches
   int          tests_run; // Comparisons
   int          n_rst;    // Reset pulses seen
   int          cycles;   // Hang guard
   localparam int BASE = 4; // Short period keeps the run brief
   warf_top #(.P_BASE(BASE)) DUT (
      .sys_clk_i(clk), .resetn_i(rstn), .reg_addr_i(addr), .reg_io_i(io),
      .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
      .por_event_i(por), .bor_event_i(bor), .pin_event_i(pin), .fuse_n_i(fuse_n),
      .gie_i(gie), .vector_ack_i(ack), .restart_i(restart), .osc_tick_i(tick),
      .wdt_irq_o(irq), .wdt_reset_o(rst_p), .reset_pc_o(pc));
   // ****************************************
   // Clock, pulse counter, hang guard
   // ****************************************
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Reset pulse is one cycle wide, so counting edges counts pulses
   always @(posedge clk) begin
      if (rst_p === 1'b1) n_rst++;
      cycles++;
      if (cycles == 20000) begin
         n_fail++;
         summarize();
      end
   end
   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic summarize();
      $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Inputs move 1 ns after the edge, never on it
   task automatic cyc();
      @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic i, input logic [7:0] d);
      cyc();
      addr = a; io = i; wdata = d; wr_s = 1'b1;
      cyc();
      wr_s = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic i, input logic [7:0] e);
      cyc();
      addr = a; io = i; rd_s = 1'b1;
      cyc();
      rd_s = 1'b0;
      chk(rdata, e);
   endtask
   task automatic ev(input int k);
      cyc();
      por = (k == 0); bor = (k == 1); pin = (k == 2);
      cyc();
      {por, bor, pin} = 3'h0;
   endtask
   // Restart, run ticks, expect the pulse after n ticks (one cycle of latency slack)
   task automatic meas(input int n);
      int k;
      cyc();
      restart = 1'b1;
      cyc();
      restart = 1'b0; tick = 1'b1; k = 0;
      while (rst_p !== 1'b1 && k < 3000) begin
         cyc();
         k++;
      end
      tick = 1'b0;
      chk(k >= n && k <= n + 1, 1'b1);
      cyc();
      chk(rst_p, 1'b0);
   endtask
   task automatic wait_irq();
      int k;
      k = 0;
      tick = 1'b1;
      while (irq !== 1'b1 && k < 100) begin
         cyc();
         k++;
      end
      tick = 1'b0;
      chk(irq, 1'b1);
   endtask
   // Clear the cause, then turn the watchdog off through the timed sequence
   task automatic off();
      wr(8'h54, 1'b0, 8'h00);
      wr(8'h60, 1'b0, 8'h18);
      wr(8'h60, 1'b0, 8'h00);
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_regs();
      rd(8'h54, 1'b0, 8'h00);
      rd(8'h34, 1'b1, 8'h00);
      rd(8'h60, 1'b0, 8'h00);
      rd(8'h40, 1'b1, 8'h00);
      chk(pc, 16'h0000);
   endtask
   task automatic t_cause();
      ev(0);
      rd(8'h54, 1'b0, 8'h01);
      ev(1);
      rd(8'h54, 1'b0, 8'h05);
      ev(2);
      rd(8'h34, 1'b1, 8'h07);
      wr(8'h54, 1'b0, 8'hfd);
      rd(8'h54, 1'b0, 8'h05);
      ev(0);
      rd(8'h54, 1'b0, 8'h01);
      wr(8'h34, 1'b1, 8'h00);
      rd(8'h54, 1'b0, 8'h00);
      chk(pc, 16'h0000);
   endtask
   task automatic t_rst();
      wr(8'h60, 1'b0, 8'h08);
      meas(BASE);
      rd(8'h54, 1'b0, 8'h08);
      wr(8'h60, 1'b0, 8'h18);
      wr(8'h60, 1'b0, 8'h00);
      rd(8'h60, 1'b0, 8'h08);
      // Power-on while the watchdog flag is still set must clear it
      ev(0);
      rd(8'h54, 1'b0, 8'h01);
      off();
      rd(8'h60, 1'b0, 8'h00);
      rd(8'h54, 1'b0, 8'h00);
   endtask
   task automatic t_presc();
      wr(8'h60, 1'b0, 8'h08);
      wr(8'h60, 1'b0, 8'h18);
      wr(8'h60, 1'b0, 8'h09);
      rd(8'h60, 1'b0, 8'h09);
      wr(8'h60, 1'b0, 8'h0b);
      rd(8'h60, 1'b0, 8'h09);
      wr(8'h60, 1'b0, 8'h18);
      rd(8'h60, 1'b0, 8'h19);
      repeat (4) cyc();
      wr(8'h60, 1'b0, 8'h0a);
      rd(8'h60, 1'b0, 8'h09);
      meas(BASE << 1);
      wr(8'h60, 1'b0, 8'h18);
      wr(8'h60, 1'b0, 8'h29);
      meas(BASE << 9);
      wr(8'h60, 1'b0, 8'h18);
      wr(8'h60, 1'b0, 8'h2a);
      meas(BASE << 9);
      off();
   endtask
   task automatic t_irq();
      int r;
      r = n_rst;
      tick = 1'b1;
      repeat (40) cyc();
      tick = 1'b0;
      rd(8'h60, 1'b0, 8'h00);
      wr(8'h60, 1'b0, 8'h40);
      tick = 1'b1;
      repeat (10) cyc();
      tick = 1'b0;
      chk(irq, 1'b0);
      rd(8'h60, 1'b0, 8'hc0);
      gie = 1'b1;
      repeat (2) cyc();
      chk(irq, 1'b1);
      wr(8'h60, 1'b0, 8'hc0);
      rd(8'h60, 1'b0, 8'h40);
      chk(irq, 1'b0);
      wait_irq();
      cyc();
      ack = 1'b1;
      cyc();
      ack = 1'b0;
      rd(8'h60, 1'b0, 8'h40);
      chk(n_rst, r);
   endtask
   task automatic t_both();
      int r;
      r = n_rst;
      wr(8'h60, 1'b0, 8'h48);
      wait_irq();
      chk(n_rst, r);
      cyc();
      ack = 1'b1;
      cyc();
      ack = 1'b0;
      rd(8'h60, 1'b0, 8'h08);
      meas(BASE);
      wr(8'h60, 1'b0, 8'h48);
      r = n_rst;
      cyc();
      restart = 1'b1;
      cyc();
      restart = 1'b0; tick = 1'b1;
      repeat (3 * BASE - 1) cyc();
      tick = 1'b0;
      chk(n_rst, r + 1);
      off();
   endtask
   task automatic t_fuse();
      int r;
      fuse_n = 1'b0;
      wr(8'h60, 1'b0, 8'h40);
      meas(BASE);
      chk(irq, 1'b0);
      fuse_n = 1'b1;
      r = n_rst;
      tick = 1'b1;
      repeat (10) begin
         cyc();
         restart = 1'b1;
         cyc();
         restart = 1'b0;
         cyc();
      end
      tick = 1'b0;
      chk(n_rst, r);
      meas(BASE);
      off();
   endtask
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      {rstn, addr, io, wr_s, rd_s, wdata, por, bor, pin} = '0;
      {gie, ack, restart, tick} = 4'h0;
      fuse_n = 1'b1;
      n_fail = 0; tests_run = 0; n_rst = 0; cycles = 0;
      repeat (10) cyc();
      rstn = 1'b1;
      t_regs();
      t_cause();
      t_rst();
      t_presc();
      t_irq();
      t_both();
      t_fuse();
      summarize();
   end
endmodule
`default_nettype wire

// ===== verilog/watchdog_reset_flag_pkg.sv
`default_nettype none
package warf_pkg;
   // ****************************************
   // Register map
   // ****************************************
   localparam logic [7:0] CAUSE_DATA_ADDR = 8'h54; // Reset-cause, data space
   localparam logic [7:0] IO_SPACE_BASE   = 8'h20; // I/O address = data - base
   localparam logic [7:0] CAUSE_IO_ADDR   = 8'h34; // Reset-cause, I/O space
   localparam logic [7:0] CTRL_DATA_ADDR  = 8'h60; // Control, data space only
   localparam logic [7:0] CAUSE_RESET     = 8'h00;
   localparam logic [7:0] CTRL_RESET      = 8'h00;
   // ****************************************
   // Field positions
   // ****************************************
   localparam int WDT_FLAG_BIT = 3; // Watchdog reset flag
   localparam int BOR_FLAG_BIT = 2; // Brown-out flag
   localparam int PIN_FLAG_BIT = 1; // Pin reset flag
   localparam int POR_FLAG_BIT = 0; // Power-on flag
   localparam int IF_BIT       = 7; // Interrupt flag
   localparam int IE_BIT       = 6; // Interrupt enable
   localparam int P3_BIT       = 5; // Prescale MSB
   localparam int CE_BIT       = 4; // Change enable
   localparam int RE_BIT       = 3; // Reset enable
   // ****************************************
   // Timing
   // ****************************************
   localparam int          OSC_FREQ_HZ     = 128000; // Watchdog oscillator
   localparam int          BASE_OSC_CYCLES = 2048;   // Period at code 0
   localparam logic [3:0]  MAX_CODE        = 4'h9;   // Highest legal code
   localparam logic [2:0]  CE_WINDOW_CYC   = 3'h4;   // Change window length
   localparam logic [15:0] RESET_VECTOR    = 16'h0000;
   // ****************************************
   // Types
   // ****************************************
   typedef struct packed {
      logic       int_flag;      // Interrupt flag
      logic       int_enable;    // Interrupt enable
      logic       presc_msb;     // Prescale bit 3
      logic       change_enable; // Timed change window
      logic       reset_enable;  // Reset action
      logic [2:0] presc_low;     // Prescale bits 2:0
   } warf_ctrl_t;
   typedef struct packed {
      logic [3:0] unused;   // Read as zero
      logic       wdt_flag; // Watchdog reset seen
      logic       bor_flag; // Brown-out seen
      logic       pin_flag; // Pin reset seen
      logic       por_flag; // Power-on seen
   } warf_cause_t;
   // Gray order along stop, irq, both, reset
   typedef enum logic [1:0] {
      WARF_STOP = 2'b00,
      WARF_IRQ  = 2'b01,
      WARF_BOTH = 2'b11,
      WARF_RST  = 2'b10
   } warf_mode_t;
endpackage
`default_nettype wire

// ===== verilog/watchdog_reset_flag_top.sv
// Operation
// RULE1: Watchdog reset sets flag; power-on/zero clears
// RULE2: Brown-out sets flag; power-on/zero clears
// RULE3: Pin reset sets flag; power-on/zero clears
// RULE4: Power-on sets flag; only zero-write clears
// RULE5: Cause register at 0x54, I/O 0x34
// RULE6: Timeout sets irq flag; vector/one clears
// RULE7: Interrupt needs global and watchdog enable
// RULE8: Enable bits select stop/irq/reset/both modes
// RULE9: Programmed fuse forces reset mode
// RULE10: Vector in combined mode clears enable, flag
// RULE11: Unserviced combined timeout causes reset
// RULE12: Software re-enables interrupt outside handler
// RULE13: Clear reset-enable, prescale only in window
// RULE14: Change enable self-clears after four cycles
// RULE15: Watchdog reset flag forces reset enable
// RULE16: Period is 2048 shifted by code
// RULE17: Control register 0x60 bit layout
// RULE18: Every reset starts at address zero
// RULE19: Software reads then clears cause early
// RULE20: Software writes change, then value, in window
// RULE21: Counter counts separate oscillator ticks
// RULE22: Reset timeout gives one-cycle reset pulse
// RULE23: Software restarts counter before timeout
// RULE24: Timeout and restart zero the counter
`timescale 1ns/10ps
`default_nettype none
module warf_top #(
   parameter int P_BASE = warf_pkg::BASE_OSC_CYCLES // Shorten for simulation
) (
   input  wire logic        sys_clk_i,
   input  wire logic        resetn_i,
   input  wire logic [7:0]  reg_addr_i,   // Register address
   input  wire logic        reg_io_i,     // Address is I/O space
   input  wire logic        reg_wr_i,     // Write strobe
   input  wire logic        reg_rd_i,     // Read strobe
   input  wire logic [7:0]  reg_wdata_i,  // Write data
   output logic      [7:0]  reg_rdata_o,  // Read data, one cycle later
   input  wire logic        por_event_i,  // Power-on reset seen
   input  wire logic        bor_event_i,  // Brown-out reset seen
   input  wire logic        pin_event_i,  // External pin reset seen
   input  wire logic        fuse_n_i,     // Always-on fuse, 0 = programmed
   input  wire logic        gie_i,        // Global interrupt enable
   input  wire logic        vector_ack_i, // Watchdog vector executing
   input  wire logic        restart_i,    // Restart instruction
   input  wire logic        osc_tick_i,   // One pulse per oscillator cycle
   output logic             wdt_irq_o,    // Interrupt request
   output logic             wdt_reset_o,  // System reset pulse
   output logic      [15:0] reset_pc_o    // Start address after reset
);
   // ****************************************
   // Helpers
   // ****************************************
   // Timeout count; reserved codes behave as the longest period
   function automatic logic [20:0] period_last(input logic [3:0] code);
      logic [3:0] c;
      c = (code > warf_pkg::MAX_CODE) ? warf_pkg::MAX_CODE : code;
      return 21'((P_BASE << c) - 1); // RULE16
   endfunction
   // Mode decode, reused by logic and checks
   function automatic warf_pkg::warf_mode_t mode_of(input logic re, input logic ie,
                                                   input logic fuse_n);
      if (!fuse_n) begin
         return warf_pkg::WARF_RST; // RULE9
      end
      case ({re, ie}) // RULE8
         2'b01:   return warf_pkg::WARF_IRQ;
         2'b10:   return warf_pkg::WARF_RST;
         2'b11:   return warf_pkg::WARF_BOTH;
         default: return warf_pkg::WARF_STOP;
      endcase
   endfunction

   // ****************************************
   // State
   // ****************************************
   warf_pkg::warf_ctrl_t  ctrl_reg,  ctrl_next;  // Control register
   warf_pkg::warf_cause_t cause_reg, cause_next; // Reset-cause register
   logic [20:0]           cnt_reg,   cnt_next;   // Oscillator count
   logic [2:0]            ce_reg,    ce_next;    // Change window left
   logic [7:0]            rdata_reg, rdata_next; // Read data
   logic                  irq_reg,   irq_next;
   logic                  rst_reg,   rst_next;
   // Decoded address selects, mode and timeout
   logic                  sel_cause;
   logic                  sel_ctrl;
   logic                  timeout;
   warf_pkg::warf_mode_t  mode;

   // Address decode for both spaces
   always_comb begin
      sel_cause = reg_io_i ? (reg_addr_i == warf_pkg::CAUSE_IO_ADDR)
                           : (reg_addr_i == warf_pkg::CAUSE_DATA_ADDR); // RULE5
      sel_ctrl  = !reg_io_i && (reg_addr_i == warf_pkg::CTRL_DATA_ADDR); // RULE17
      mode      = mode_of(ctrl_reg.reset_enable, ctrl_reg.int_enable, fuse_n_i);
      timeout   = (mode != warf_pkg::WARF_STOP) && osc_tick_i &&
                  (cnt_reg == period_last({ctrl_reg.presc_msb, ctrl_reg.presc_low}));
   end

   // ****************************************
   // Counter and timeout action
   // ****************************************
   // Count oscillator ticks; zero on timeout, restart or stop
   always_comb begin
      cnt_next = cnt_reg;
      rst_next = 1'b0;
      if (timeout || restart_i || mode == warf_pkg::WARF_STOP) begin
         cnt_next = '0; // RULE24
      end else if (osc_tick_i) begin
         cnt_next = cnt_reg + 21'h000001; // RULE21
      end
      if (timeout) begin
         // Combined mode resets only when the flag is still pending
         case (mode)
            warf_pkg::WARF_RST:  rst_next = 1'b1; // RULE22
            warf_pkg::WARF_BOTH: rst_next = ctrl_reg.int_flag; // RULE11
            default:             rst_next = 1'b0;
         endcase
      end
   end

   // ****************************************
   // Reset-cause flags
   // ****************************************
   // Events win over a software clear in the same cycle
   always_comb begin
      cause_next = cause_reg;
      if (reg_wr_i && sel_cause) begin
         cause_next.wdt_flag = cause_reg.wdt_flag & reg_wdata_i[warf_pkg::WDT_FLAG_BIT];
         cause_next.bor_flag = cause_reg.bor_flag & reg_wdata_i[warf_pkg::BOR_FLAG_BIT];
         cause_next.pin_flag = cause_reg.pin_flag & reg_wdata_i[warf_pkg::PIN_FLAG_BIT];
         cause_next.por_flag = cause_reg.por_flag & reg_wdata_i[warf_pkg::POR_FLAG_BIT]; // RULE4
      end
      if (por_event_i) begin
         cause_next.wdt_flag = 1'b0; // RULE1
         cause_next.bor_flag = 1'b0; // RULE2
         cause_next.pin_flag = 1'b0; // RULE3
         cause_next.por_flag = 1'b1; // RULE4
      end
      if (rst_next) begin
         cause_next.wdt_flag = 1'b1; // RULE1
      end
      if (bor_event_i) begin
         cause_next.bor_flag = 1'b1; // RULE2
      end
      if (pin_event_i) begin
         cause_next.pin_flag = 1'b1; // RULE3
      end
      cause_next.unused = 4'h0;
   end

   // ****************************************
   // Control register
   // ****************************************
   // Software prescale changes and reset-enable clears happen only inside the timed window
   always_comb begin
      ctrl_next = ctrl_reg;
      ce_next   = (ce_reg != 3'h0) ? ce_reg - 3'h1 : 3'h0; // RULE14
      if (reg_wr_i && sel_ctrl) begin
         ctrl_next.int_enable = reg_wdata_i[warf_pkg::IE_BIT];
         if (reg_wdata_i[warf_pkg::IF_BIT]) begin
            ctrl_next.int_flag = 1'b0; // RULE6
         end
         if (ce_reg != 3'h0) begin
            ctrl_next.reset_enable = reg_wdata_i[warf_pkg::RE_BIT]; // RULE13
            ctrl_next.presc_msb    = reg_wdata_i[warf_pkg::P3_BIT];
            ctrl_next.presc_low    = reg_wdata_i[2:0];
         end else begin
            // Setting is always allowed, clearing is not
            ctrl_next.reset_enable = ctrl_reg.reset_enable | reg_wdata_i[warf_pkg::RE_BIT];
         end
         if (reg_wdata_i[warf_pkg::CE_BIT] && reg_wdata_i[warf_pkg::RE_BIT]) begin
            ce_next = warf_pkg::CE_WINDOW_CYC; // RULE14
         end else begin
            ce_next = 3'h0; // Second write closes the window
         end
      end
      if (vector_ack_i) begin
         ctrl_next.int_flag = 1'b0; // RULE6
         if (mode == warf_pkg::WARF_BOTH) begin
            ctrl_next.int_enable = 1'b0; // RULE10
         end
      end
      if (timeout && (mode == warf_pkg::WARF_IRQ || mode == warf_pkg::WARF_BOTH)) begin
         ctrl_next.int_flag = 1'b1; // RULE6
      end
      if (por_event_i || bor_event_i || pin_event_i || rst_next) begin
         ctrl_next = warf_pkg::CTRL_RESET;
         ce_next   = 3'h0;
      end
      if (cause_next.wdt_flag || !fuse_n_i) begin
         ctrl_next.reset_enable = 1'b1; // RULE15
      end
      if (!fuse_n_i) begin
         ctrl_next.int_enable = 1'b0; // RULE9
      end
      ctrl_next.change_enable = (ce_next != 3'h0);
   end

   // ****************************************
   // Outputs
   // ****************************************
   // Registered read data; unmapped reads give zero
   always_comb begin
      rdata_next = 8'h00;
      if (reg_rd_i && sel_cause) begin
         rdata_next = cause_reg;
      end else if (reg_rd_i && sel_ctrl) begin
         rdata_next = ctrl_reg;
      end
      irq_next = ctrl_next.int_flag && ctrl_next.int_enable && gie_i; // RULE7
   end

   // Register all state
   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         ctrl_reg   <= warf_pkg::CTRL_RESET;
         cause_reg  <= warf_pkg::CAUSE_RESET;
         cnt_reg    <= '0;
         ce_reg     <= 3'h0;
         rdata_reg  <= 8'h00;
         irq_reg    <= 1'b0;
         rst_reg    <= 1'b0;
         reset_pc_o <= warf_pkg::RESET_VECTOR; // RULE18
      end else begin
         ctrl_reg   <= ctrl_next;
         cause_reg  <= cause_next;
         cnt_reg    <= cnt_next;
         ce_reg     <= ce_next;
         rdata_reg  <= rdata_next;
         irq_reg    <= irq_next;
         rst_reg    <= rst_next;
         reset_pc_o <= warf_pkg::RESET_VECTOR; // RULE18
      end
   end

   assign reg_rdata_o = rdata_reg;
   assign wdt_irq_o   = irq_reg;
   assign wdt_reset_o = rst_reg;

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!resetn_i);

   sequence ce_opened;
      reg_wr_i && sel_ctrl && reg_wdata_i[warf_pkg::CE_BIT] && reg_wdata_i[warf_pkg::RE_BIT]
      && !por_event_i && !bor_event_i && !pin_event_i && !rst_next;
   endsequence
   sequence ce_quiet;
      !(reg_wr_i && sel_ctrl) && !por_event_i && !bor_event_i && !pin_event_i && !rst_next;
   endsequence

   chk_ce_window: assert property (ce_opened ##1 ce_quiet [*4] |=> !ctrl_reg.change_enable) // RULE14
      else $error("Change enable did not clear after four cycles");
   // A second control write may close the window early, so only quiet cycles count
   chk_ce_open: assert property (ce_opened ##1 ce_quiet [*3] |=> ctrl_reg.change_enable) // RULE14
      else $error("Change enable window shorter than four cycles");
   chk_re_lock: assert property (ctrl_reg.reset_enable && ce_reg == 3'h0 && !por_event_i // RULE13
      && !bor_event_i && !pin_event_i |=> ctrl_reg.reset_enable)
      else $error("Reset enable cleared outside change window");
   chk_watchdog_reset_flag_force: assert property (cause_reg.wdt_flag |-> ctrl_reg.reset_enable) // RULE15
      else $error("Reset enable low while watchdog flag set");
   chk_rst_pulse: assert property (wdt_reset_o |=> !wdt_reset_o) // RULE22
      else $error("Watchdog reset longer than one cycle");
   chk_rst_flag: assert property (rst_next && !por_event_i |=> cause_reg.wdt_flag && wdt_reset_o) // RULE1
      else $error("Watchdog reset did not set its flag");
   chk_fuse_force: assert property (!fuse_n_i && timeout |=> wdt_reset_o) // RULE9
      else $error("Programmed fuse timeout gave no reset");
   chk_irq_gate: assert property (wdt_irq_o |-> $past(gie_i) && ctrl_reg.int_enable // RULE7
      && ctrl_reg.int_flag)
      else $error("Interrupt raised without both enables");
   chk_vec_both: assert property (vector_ack_i && mode == warf_pkg::WARF_BOTH && !timeout // RULE10
      |=> !ctrl_reg.int_enable && !ctrl_reg.int_flag)
      else $error("Vector did not drop to reset mode");
   chk_por_flag: assert property (por_event_i |=> cause_reg.por_flag && !cause_reg.bor_flag // RULE4
      || $past(bor_event_i))
      else $error("Power-on event flags wrong");
   chk_cnt_zero: assert property (restart_i |=> cnt_reg == 21'h000000) // RULE24
      else $error("Restart did not zero counter");
   chk_tout_zero: assert property (timeout |=> cnt_reg == 21'h000000) // RULE24
      else $error("Timeout did not zero counter");
   // Timeout in an interrupt mode raises the flag unless a reset wipes it
   chk_irq_set: assert property (timeout && mode inside {warf_pkg::WARF_IRQ, warf_pkg::WARF_BOTH} // RULE6
      && !rst_next && !por_event_i && !bor_event_i && !pin_event_i |=> ctrl_reg.int_flag)
      else $error("Timeout did not set interrupt flag");
   // Combined mode with the flag still pending must reset
   chk_both_rst: assert property (timeout && mode == warf_pkg::WARF_BOTH && ctrl_reg.int_flag // RULE11
      |=> wdt_reset_o)
      else $error("Unserviced combined timeout gave no reset");
   // First combined timeout only interrupts
   chk_both_irq: assert property (timeout && mode == warf_pkg::WARF_BOTH && !ctrl_reg.int_flag // RULE8
      |=> !wdt_reset_o)
      else $error("First combined timeout reset the device");
   // Stopped watchdog never resets
   chk_stop_quiet: assert property (mode == warf_pkg::WARF_STOP |=> !wdt_reset_o) // RULE8
      else $error("Stopped watchdog gave a reset");
   // Reset-cause flags follow their event
   chk_bor_flag: assert property (bor_event_i |=> cause_reg.bor_flag) // RULE2
      else $error("Brown-out event did not set its flag");
   chk_pin_flag: assert property (pin_event_i |=> cause_reg.pin_flag) // RULE3
      else $error("Pin event did not set its flag");
   // Read data is the register as it stood when the strobe was taken
   chk_rd_cause: assert property (reg_rd_i && sel_cause |=> reg_rdata_o == $past(cause_reg)) // RULE5
      else $error("Cause read returned wrong data");
endmodule
`default_nettype wire
